// >>> pkg/stcb_pkg.sv
`default_nettype none
package stcb_pkg;
	// register indices on the plain register port
	localparam logic [2:0] ADDR_TX_CTRL = 3'h0;
	localparam logic [2:0] ADDR_RX_CTRL = 3'h1;
	localparam logic [2:0] ADDR_BAUD_CTRL = 3'h2;
	localparam logic [2:0] ADDR_DIV_LO = 3'h3;
	localparam logic [2:0] ADDR_DIV_HI = 3'h4;
	localparam logic [2:0] ADDR_TX_DATA = 3'h5;
	localparam logic [2:0] ADDR_RX_DATA = 3'h6;
	// writable bits of each control register
	localparam logic [7:0] TX_WR_MASK = 8'hFD;
	localparam logic [7:0] RX_WR_MASK = 8'hF8;
	localparam logic [7:0] BAUD_WR_MASK = 8'h9B;
	// values after reset of the stored parts
	localparam logic [7:0] TX_CTRL_RST = 8'h00;
	localparam logic [7:0] RX_CTRL_RST = 8'h00;
	localparam logic [7:0] BAUD_CTRL_RST = 8'h00;
	localparam logic [7:0] DIV_RST = 8'h00;
	// field position used by the overrun clear decode
	localparam int RX_BIT_CONT_RECV = 4;
	// baud timer ticks per bit: async low, async high or 16-bit, sync
	localparam logic [6:0] TICKS_ASYNC_LOW = 7'h40;
	localparam logic [6:0] TICKS_ASYNC_HIGH = 7'h10;
	localparam logic [6:0] TICKS_SYNC = 7'h04;
	// frame lengths in bit times, stop bit included in async and break frames; sync lengths are data bits only
	localparam logic [3:0] FRAME_LEN_8 = 4'hA;
	localparam logic [3:0] FRAME_LEN_9 = 4'hB;
	localparam logic [3:0] FRAME_LEN_BREAK = 4'hD;
	localparam logic [3:0] SYNC_LEN_8 = 4'h8;
	localparam logic [3:0] SYNC_LEN_9 = 4'h9;
	// twelve low bit times then one high stop bit
	localparam logic [12:0] BREAK_FRAME = 13'h1000;
	localparam logic [12:0] LINE_IDLE = 13'h1FFF;
	// auto-baud: count over eight bit times, clocks = 8 * ticks * (n+1)
	localparam int ABD_CNT_W = 25;
	localparam int ABD_SHIFT_LOW = 9;
	localparam int ABD_SHIFT_HIGH = 7;
	localparam logic [2:0] ABD_LAST_RISE = 3'h5;

	typedef struct packed {
		logic clock_source_select;
		logic tx_nine_bit_select;
		logic transmit_enable;
		logic sync_mode;
		logic break_request;
		logic high_speed_select;
		logic shift_register_empty;
		logic tx_ninth_data;
	} stcb_tx_ctrl_t;

	typedef struct packed {
		logic port_enable;
		logic rx_nine_bit_select;
		logic single_receive_enable;
		logic continuous_receive_enable;
		logic address_detect_enable;
		logic framing_error_flag;
		logic overrun_error_flag;
		logic rx_ninth_data;
	} stcb_rx_ctrl_t;

	typedef struct packed {
		logic autobaud_rollover_flag;
		logic receive_idle_flag;
		logic spare5;
		logic clock_polarity_select;
		logic divider_width_select;
		logic spare2;
		logic wakeup_enable;
		logic autobaud_enable;
	} stcb_baud_ctrl_t;

	typedef enum logic [1:0] {ABD_IDLE, ABD_START, ABD_COUNT} stcb_abd_t;
endpackage
`default_nettype wire

// >>> rtl/stcb_core.sv
// The strobed register port and the register addresses were chosen for this implementation.
`default_nettype none
module stcb_core
	import stcb_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output var logic [7:0] o_rdata,
	input wire logic i_tx_clk_in,
	output var logic o_tx_clk_out,
	output var logic o_tx_clk_oe_n,
	input wire logic i_rx_dat_in,
	output var logic o_rx_dat_out,
	output var logic o_rx_dat_oe_n,
	output var logic o_tx_buf_full,
	output var logic o_rx_ready,
	output var logic o_rx_event,
	output var logic o_wake_event
);
	stcb_tx_ctrl_t txc; // transmit control, stored part
	stcb_rx_ctrl_t rxc; // receive control, stored part
	stcb_baud_ctrl_t bdc; // baud control, stored part
	logic [7:0] div_lo; // divider low byte
	logic [7:0] div_hi; // divider high byte
	logic [15:0] baud_timer; // free-running down counter
	logic [15:0] div_n; // divisor in use
	logic tick; // one baud timer rollover
	logic port_on;
	logic async_mode;
	logic master;
	logic [6:0] bit_ticks; // ticks per bit time
	logic [6:0] mid; // centre of a bit in ticks
	logic [12:0] tx_sh; // transmit shift register, lsb on line
	logic [3:0] tx_left; // bit times still to send
	logic [6:0] tx_ph; // tick phase inside a bit
	logic tx_active;
	logic tx_brk; // frame in flight is a break
	logic [7:0] tx_buf; // transmit holding byte
	logic tx_go;
	logic tx_step;
	logic brk_done;
	logic sphase; // sync clock active half
	logic shalf; // tick pair counter for sync clock
	logic slv_prev; // last sampled external clock, polarity removed
	logic slv_now;
	logic sclk_lead;
	logic sclk_trail;
	logic sync_busy;
	logic rx_sync_run;
	logic rx_prev; // last sampled receive line
	logic rx_active;
	logic [6:0] rx_ph;
	logic [3:0] rx_idx; // 0 start, then data, then stop
	logic [1:0] votes; // high samples so far in this bit
	logic vote_bit;
	logic [2:0] vote_sum;
	logic [8:0] rx_sh;
	logic [8:0] rx_sh_next;
	logic [3:0] rx_nb;
	logic start_ok;
	logic rx_done; // one character finished, registered
	logic [8:0] rx_word;
	logic rx_bad; // stop bit was low
	logic [8:0] rx_data; // receive buffer
	logic rx_framing_error_flag;
	logic rx_overrun_error_flag;
	logic rd_rx;
	logic continuous_receive_enable_clear;
	logic accept;
	logic single_done;
	logic div_wr;
	logic wake_seen;
	logic wake_clear;
	stcb_abd_t abd_state;
	logic [ABD_CNT_W-1:0] abd_cnt;
	logic [2:0] abd_rises;
	logic abd_done;
	logic abd_ovf;
	logic [15:0] abd_div;
	stcb_tx_ctrl_t tx_rd;
	stcb_rx_ctrl_t rx_rd;
	stcb_baud_ctrl_t bd_rd;

	// aligns a received word: 8-bit frames sit in the top of the shifter
	function automatic logic [8:0] align(input logic [8:0] sh,
		input logic nine);
		align = nine ? sh : {1'b0, sh[8:1]};
	endfunction

	// mode decode and divisor selection
	always_comb
	begin
		port_on = rxc.port_enable;
		async_mode = ~txc.sync_mode;
		master = txc.sync_mode & txc.clock_source_select;
		div_n = bdc.divider_width_select ? {div_hi, div_lo}
			: {8'h00, div_lo};
		if (txc.sync_mode)
			bit_ticks = TICKS_SYNC;
		else if (txc.high_speed_select | bdc.divider_width_select)
			bit_ticks = TICKS_ASYNC_HIGH;
		else
			bit_ticks = TICKS_ASYNC_LOW;
		mid = bit_ticks >> 1;
		tick = port_on & (baud_timer == 16'h0000);
		div_wr = i_wr & ((i_addr == ADDR_DIV_LO) | (i_addr == ADDR_DIV_HI));
		rd_rx = i_rd & (i_addr == ADDR_RX_DATA);
		continuous_receive_enable_clear = i_wr & (i_addr == ADDR_RX_CTRL)
			& ~i_wdata[RX_BIT_CONT_RECV];
	end

	// receive enables and transmit hand-off
	always_comb
	begin
		// continuous receive wins over single receive in sync mode
		rx_sync_run = port_on & txc.sync_mode & ~rx_overrun_error_flag
			& (rxc.continuous_receive_enable
			| (master & rxc.single_receive_enable));
		sync_busy = port_on & txc.sync_mode & (rx_sync_run | tx_active);
		// sync receive takes the data line away from the transmitter
		// async loads wait for a tick so the start bit is full length
		tx_go = port_on & txc.transmit_enable & ~tx_active & o_tx_buf_full
			& ~rx_sync_run & (tick | txc.sync_mode);
		slv_now = i_tx_clk_in ^ bdc.clock_polarity_select;
		if (master)
		begin
			sclk_lead = sync_busy & tick & shalf & ~sphase;
			sclk_trail = sync_busy & tick & shalf & sphase;
		end
		else
		begin
			sclk_lead = sync_busy & slv_now & ~slv_prev;
			sclk_trail = sync_busy & ~slv_now & slv_prev;
		end
		if (async_mode)
			tx_step = tick & (tx_ph == bit_ticks - 7'h01);
		else
			tx_step = sclk_trail & ~rx_sync_run;
		brk_done = tx_active & tx_brk & tx_step & (tx_left == 4'h1);
	end

	// receive helpers: majority vote, frame length, acceptance
	always_comb
	begin
		vote_sum = {1'b0, votes} + {2'b00, i_rx_dat_in};
		vote_bit = vote_sum >= 3'h2;
		rx_nb = rxc.rx_nine_bit_select ? SYNC_LEN_9 : SYNC_LEN_8;
		rx_sh_next = {i_rx_dat_in, rx_sh[8:1]};
		// start edge only when no other function owns the line
		start_ok = async_mode & port_on & rxc.continuous_receive_enable
			& ~bdc.wakeup_enable & ~bdc.autobaud_enable & ~rx_overrun_error_flag
			& rx_prev & ~i_rx_dat_in;
		accept = ~(async_mode & rxc.rx_nine_bit_select
			& rxc.address_detect_enable & ~rx_word[8]);
		single_done = rx_done & txc.sync_mode & master
			& rxc.single_receive_enable & ~rxc.continuous_receive_enable;
		wake_clear = wake_seen & ~rx_prev & i_rx_dat_in;
	end

	// control registers: hardware clears, then software writes
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			txc <= stcb_tx_ctrl_t'(TX_CTRL_RST);
			rxc <= stcb_rx_ctrl_t'(RX_CTRL_RST);
			bdc <= stcb_baud_ctrl_t'(BAUD_CTRL_RST);
			div_lo <= DIV_RST;
			div_hi <= DIV_RST;
		end
		else if (i_clk_en)
		begin
			if (brk_done)
				txc.break_request <= 1'b0;
			if (single_done)
				rxc.single_receive_enable <= 1'b0;
			if (wake_clear)
				bdc.wakeup_enable <= 1'b0;
			if (abd_done)
			begin
				// measured divisor replaces the programmed one
				bdc.autobaud_enable <= 1'b0;
				div_lo <= abd_div[7:0];
				div_hi <= abd_div[15:8];
			end
			if (i_wr)
			begin
				case (i_addr)
					ADDR_TX_CTRL: txc <= stcb_tx_ctrl_t'(i_wdata & TX_WR_MASK);
					ADDR_RX_CTRL: rxc <= stcb_rx_ctrl_t'(i_wdata & RX_WR_MASK);
					ADDR_BAUD_CTRL: bdc <= stcb_baud_ctrl_t'(i_wdata
						& BAUD_WR_MASK);
					ADDR_DIV_LO: div_lo <= i_wdata;
					ADDR_DIV_HI: div_hi <= i_wdata;
					default: ; // other indices store nothing here
				endcase
			end
			// a rollover in the same cycle as a software clear survives
			if (abd_ovf)
				bdc.autobaud_rollover_flag <= 1'b1;
		end
	end

	// baud timer: reloads on rollover, on divider writes, on auto-baud
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
			baud_timer <= 16'h0000;
		else if (i_clk_en)
		begin
			if (!port_on || div_wr || abd_done)
				baud_timer <= div_n;
			else if (baud_timer == 16'h0000)
				baud_timer <= div_n;
			else
				baud_timer <= baud_timer - 16'h0001;
		end
	end

	// transmit holding byte; a write lands while the port is on, even over unsent data
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			tx_buf <= 8'h00;
			o_tx_buf_full <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (!port_on)
				o_tx_buf_full <= 1'b0;
			else if (i_wr && i_addr == ADDR_TX_DATA)
			begin
				tx_buf <= i_wdata;
				o_tx_buf_full <= 1'b1;
			end
			else if (tx_go)
				o_tx_buf_full <= 1'b0;
		end
	end

	// transmit shifter; a break consumes the held byte as a dummy
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			tx_sh <= LINE_IDLE;
			tx_left <= 4'h0;
			tx_ph <= 7'h00;
			tx_active <= 1'b0;
			tx_brk <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (!port_on)
			begin
				tx_sh <= LINE_IDLE;
				tx_left <= 4'h0;
				tx_ph <= 7'h00;
				tx_active <= 1'b0;
				tx_brk <= 1'b0;
			end
			else if (tx_go)
			begin
				tx_active <= 1'b1;
				tx_ph <= 7'h00;
				tx_brk <= async_mode & txc.break_request;
				if (txc.sync_mode)
				begin
					// sync frames are bare data bits, lsb first
					tx_sh <= {4'hF, txc.tx_ninth_data, tx_buf};
					tx_left <= txc.tx_nine_bit_select ? SYNC_LEN_9
						: SYNC_LEN_8;
				end
				else if (txc.break_request)
				begin
					tx_sh <= BREAK_FRAME;
					tx_left <= FRAME_LEN_BREAK;
				end
				else if (txc.tx_nine_bit_select)
				begin
					tx_sh <= {3'b111, txc.tx_ninth_data, tx_buf, 1'b0};
					tx_left <= FRAME_LEN_9;
				end
				else
				begin
					tx_sh <= {4'hF, tx_buf, 1'b0};
					tx_left <= FRAME_LEN_8;
				end
			end
			else if (tx_active && tx_step)
			begin
				tx_ph <= 7'h00;
				tx_sh <= {1'b1, tx_sh[12:1]};
				tx_left <= tx_left - 4'h1;
				if (tx_left == 4'h1)
					tx_active <= 1'b0;
			end
			else if (tx_active && async_mode && tick)
				tx_ph <= tx_ph + 7'h01;
		end
	end

	// sync clock: master makes it from ticks, slave samples the pin
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			sphase <= 1'b0;
			shalf <= 1'b0;
			slv_prev <= 1'b0;
		end
		else if (i_clk_en)
		begin
			slv_prev <= slv_now;
			if (!sync_busy)
			begin
				sphase <= 1'b0;
				shalf <= 1'b0;
			end
			else if (master && tick)
			begin
				// two ticks per half period gives four ticks per bit
				shalf <= ~shalf;
				if (shalf)
					sphase <= ~sphase;
			end
		end
	end

	// receive shifter for both modes
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			rx_prev <= 1'b1;
			rx_active <= 1'b0;
			rx_ph <= 7'h00;
			rx_idx <= 4'h0;
			votes <= 2'b00;
			rx_sh <= 9'h000;
			rx_done <= 1'b0;
			rx_word <= 9'h000;
			rx_bad <= 1'b0;
		end
		else if (i_clk_en)
		begin
			rx_prev <= i_rx_dat_in;
			rx_done <= 1'b0;
			if (!port_on)
			begin
				rx_active <= 1'b0;
				rx_idx <= 4'h0;
				votes <= 2'b00;
			end
			else if (txc.sync_mode)
			begin
				// sampled on the leading clock edge; far end changes on trail
				if (rx_sync_run && sclk_lead)
				begin
					rx_sh <= rx_sh_next;
					if (rx_idx == rx_nb - 4'h1)
					begin
						rx_idx <= 4'h0;
						rx_active <= 1'b0;
						rx_done <= 1'b1;
						rx_word <= align(rx_sh_next, rxc.rx_nine_bit_select);
						rx_bad <= 1'b0;
					end
					else
					begin
						rx_idx <= rx_idx + 4'h1;
						rx_active <= 1'b1;
					end
				end
				else if (!rx_sync_run)
				begin
					rx_active <= 1'b0;
					rx_idx <= 4'h0;
				end
			end
			else if (!rx_active)
			begin
				// start edge may land between ticks: up to one tick of skew
				if (start_ok)
				begin
					rx_active <= 1'b1;
					rx_ph <= 7'h00;
					rx_idx <= 4'h0;
					votes <= 2'b00;
				end
			end
			else if (tick)
			begin
				if (rx_ph == bit_ticks - 7'h01)
				begin
					rx_ph <= 7'h00;
					rx_idx <= rx_idx + 4'h1;
				end
				else
					rx_ph <= rx_ph + 7'h01;
				if (rx_ph == mid - 7'h01 || rx_ph == mid)
					votes <= vote_sum[1:0];
				if (rx_ph == mid + 7'h01)
				begin
					votes <= 2'b00;
					if (rx_idx == 4'h0)
					begin
						if (vote_bit)
							rx_active <= 1'b0; // glitch, not a start bit
					end
					else if (rx_idx == rx_nb + 4'h1)
					begin
						rx_active <= 1'b0;
						rx_done <= 1'b1;
						rx_word <= align(rx_sh, rxc.rx_nine_bit_select);
						rx_bad <= ~vote_bit;
					end
					else
						rx_sh <= {vote_bit, rx_sh[8:1]};
				end
			end
		end
	end

	// receive buffer and error flags; receiver stalls while overrun
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			rx_data <= 9'h000;
			o_rx_ready <= 1'b0;
			o_rx_event <= 1'b0;
			rx_framing_error_flag <= 1'b0;
			rx_overrun_error_flag <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_rx_event <= 1'b0;
			if (!port_on)
			begin
				o_rx_ready <= 1'b0;
				rx_framing_error_flag <= 1'b0;
				rx_overrun_error_flag <= 1'b0;
			end
			else
			begin
				if (rd_rx)
					o_rx_ready <= 1'b0;
				if (continuous_receive_enable_clear)
					rx_overrun_error_flag <= 1'b0;
				if (rx_done && accept)
				begin
					// a read in this cycle frees the buffer in time
					if (o_rx_ready && !rd_rx)
						rx_overrun_error_flag <= 1'b1;
					else
					begin
						rx_data <= rx_word;
						rx_framing_error_flag <= rx_bad;
						o_rx_ready <= 1'b1;
						o_rx_event <= 1'b1;
					end
				end
			end
		end
	end

	// wake-up watch of the receive line
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			wake_seen <= 1'b0;
			o_wake_event <= 1'b0;
		end
		else if (i_clk_en)
		begin
			o_wake_event <= 1'b0;
			if (!port_on || !async_mode || !bdc.wakeup_enable)
				wake_seen <= 1'b0;
			else if (rx_prev && !i_rx_dat_in)
			begin
				wake_seen <= 1'b1;
				o_wake_event <= 1'b1;
			end
			else if (wake_clear)
				wake_seen <= 1'b0;
		end
	end

	// auto-baud: clocks from first to fifth rising edge of the 55h field
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			abd_state <= ABD_IDLE;
			abd_cnt <= '0;
			abd_rises <= 3'h0;
			abd_done <= 1'b0;
			abd_ovf <= 1'b0;
			abd_div <= 16'h0000;
		end
		else if (i_clk_en)
		begin
			abd_done <= 1'b0;
			abd_ovf <= 1'b0;
			if (!port_on || !async_mode || !bdc.autobaud_enable)
				abd_state <= ABD_IDLE;
			else
			begin
				unique case (abd_state)
					ABD_IDLE:
						if (rx_prev && !i_rx_dat_in && !abd_done)
							abd_state <= ABD_START;
					ABD_START:
						if (!rx_prev && i_rx_dat_in)
						begin
							abd_state <= ABD_COUNT;
							// the edge cycle itself counts: span is whole bits
							abd_cnt <= ABD_CNT_W'(1);
							abd_rises <= 3'h1;
						end
					ABD_COUNT:
					begin
						// counter pins at all ones rather than wrapping
						if (abd_cnt == '1)
							abd_ovf <= 1'b1;
						else
							abd_cnt <= abd_cnt + ABD_CNT_W'(1);
						if (!rx_prev && i_rx_dat_in)
						begin
							abd_rises <= abd_rises + 3'h1;
							if (abd_rises + 3'h1 == ABD_LAST_RISE)
							begin
								abd_state <= ABD_IDLE;
								abd_done <= 1'b1;
								if (bit_ticks == TICKS_ASYNC_HIGH)
									abd_div <= abd_cnt[ABD_SHIFT_HIGH +: 16]
										- 16'h0001;
								else
									abd_div <= abd_cnt[ABD_SHIFT_LOW +: 16]
										- 16'h0001;
							end
						end
					end
				endcase
			end
		end
	end

	// pin drivers; enables are active low, released while port is off
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
		begin
			o_tx_clk_out <= 1'b1;
			o_tx_clk_oe_n <= 1'b1;
			o_rx_dat_out <= 1'b1;
			o_rx_dat_oe_n <= 1'b1;
		end
		else if (i_clk_en)
		begin
			if (async_mode)
			begin
				o_tx_clk_out <= tx_sh[0];
				o_tx_clk_oe_n <= ~port_on;
				o_rx_dat_out <= 1'b1;
				o_rx_dat_oe_n <= 1'b1;
			end
			else
			begin
				o_tx_clk_out <= sphase ^ bdc.clock_polarity_select;
				o_tx_clk_oe_n <= ~(port_on & master);
				o_rx_dat_out <= tx_sh[0];
				o_rx_dat_oe_n <= ~(port_on & tx_active & ~rx_sync_run);
			end
		end
	end

	// read views with live status folded in
	always_comb
	begin
		tx_rd = txc;
		tx_rd.shift_register_empty = ~tx_active;
		rx_rd = rxc;
		rx_rd.framing_error_flag = rx_framing_error_flag;
		rx_rd.overrun_error_flag = rx_overrun_error_flag;
		rx_rd.rx_ninth_data = rx_data[8];
		bd_rd = bdc;
		bd_rd.receive_idle_flag = ~rx_active;
		bd_rd.spare5 = 1'b0;
		bd_rd.spare2 = 1'b0;
	end

	// read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
			o_rdata <= 8'h00;
		else if (i_clk_en)
		begin
			o_rdata <= 8'h00;
			if (i_rd)
			begin
				case (i_addr)
					ADDR_TX_CTRL: o_rdata <= tx_rd;
					ADDR_RX_CTRL: o_rdata <= rx_rd;
					ADDR_BAUD_CTRL: o_rdata <= bd_rd;
					ADDR_DIV_LO: o_rdata <= div_lo;
					ADDR_DIV_HI: o_rdata <= div_hi;
					ADDR_RX_DATA: o_rdata <= rx_data[7:0];
					default: o_rdata <= 8'h00; // unmapped or write-only
				endcase
			end
		end
	end
endmodule // stcb_core
`default_nettype wire

// >>> sim/stcb_core_monitor.sv
`default_nettype none
// port-level checker, judged only from the pins of the control block
module stcb_core_monitor
	import stcb_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_clk_en,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_tx_clk_oe_n,
	input wire logic o_rx_dat_oe_n,
	input wire logic o_tx_buf_full,
	input wire logic o_rx_ready,
	input wire logic o_rx_event
);
	logic pen; // shadow of port enable, rebuilt from bus writes
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);
	// shadow kept here so no internal state has to be probed
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_resetn)
			pen <= 1'b0;
		else if (i_clk_en && i_wr && i_addr == ADDR_RX_CTRL)
			pen <= i_wdata[7];
	end
	property p_pins_off;
		!pen && !$past(pen) && !$past(pen, 2)
		|-> o_tx_clk_oe_n && o_rx_dat_oe_n;
	endproperty
	a_pins_off: assert property (p_pins_off)
		else $error("pin driven while port off");
	property p_rdata_idle;
		!$past(i_rd) |-> o_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside read slot");
	property p_unmapped;
		i_rd && i_addr == 3'h7 |=> o_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped index not zero");
	property p_spare_zero;
		i_rd && i_addr == ADDR_BAUD_CTRL |=> !o_rdata[5] && !o_rdata[2];
	endproperty
	a_spare_zero: assert property (p_spare_zero)
		else $error("spare baud bits not zero");
	property p_idle_off;
		i_rd && i_addr == ADDR_BAUD_CTRL && !pen |=> o_rdata[6];
	endproperty
	a_idle_off: assert property (p_idle_off)
		else $error("receiver not idle while off");
	property p_txfull;
		i_wr && i_addr == ADDR_TX_DATA && pen |=> o_tx_buf_full;
	endproperty
	a_txfull: assert property (p_txfull)
		else $error("transmit byte not held");
	property p_evt_pulse;
		o_rx_event |-> o_rx_ready ##1 !o_rx_event;
	endproperty
	a_evt_pulse: assert property (p_evt_pulse)
		else $error("receive event malformed");
	property p_rd_clear;
		i_rd && i_addr == ADDR_RX_DATA |=> !o_rx_ready || o_rx_event;
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("buffer not freed by read");
endmodule // stcb_core_monitor
bind stcb_core stcb_core_monitor u_mon (
	.i_ref_clk(i_ref_clk),
	.i_resetn(i_resetn),
	.i_clk_en(i_clk_en),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.o_tx_clk_oe_n(o_tx_clk_oe_n),
	.o_rx_dat_oe_n(o_rx_dat_oe_n),
	.o_tx_buf_full(o_tx_buf_full),
	.o_rx_ready(o_rx_ready),
	.o_rx_event(o_rx_event)
);
`default_nettype wire

// >>> sim/stcb_peer.sv
`default_nettype none
// far-end terminal: sends on our receive line, listens to our transmit
module stcb_peer (
	input wire logic i_clk,
	input wire logic i_line,
	output logic o_line
);
	timeunit 1ns;
	timeprecision 100ps;
	initial o_line = 1'b1; // idle high between frames
	// hold one level for k clocks, launched just after an edge
	task automatic drive(input logic v, input int k);
		@(posedge i_clk);
		o_line <= v;
		repeat (k - 1) @(posedge i_clk);
	endtask
	// start, lsb first data, stop of chosen level, then idle
	task automatic send(input logic [8:0] d, input int n, input int b,
		input logic stop);
		int i;
		drive(1'b0, b);
		for (i = 0; i < n; i++)
			drive(d[i], b);
		drive(stop, b);
		drive(1'b1, b);
	endtask
	// sample each data bit mid-way; stop bit is not waited for
	task automatic recv(output logic [8:0] d, input int n, input int b);
		int i;
		d = 9'h000;
		@(negedge i_line);
		repeat (b / 2) @(posedge i_clk);
		for (i = 0; i < n; i++)
		begin
			repeat (b) @(posedge i_clk);
			d[i] = i_line;
		end
	endtask
	// clocks that the line stays low after its next falling edge
	task automatic lowtime(output int c);
		c = 0;
		@(negedge i_line);
		while (i_line === 1'b0)
		begin
			@(posedge i_clk);
			#1;
			c++;
		end
	endtask
endmodule // stcb_peer
`default_nettype wire

// >>> sim/tb.sv
`default_nettype none
module tb
	import stcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_n, wr_s, rd_s, peer_tx; // bus strobes, peer drive
	logic [2:0] addr;
	logic [7:0] wdata, rdata;
	logic tx_out, tx_oe_n, rx_out, rx_oe_n, buf_full, rx_rdy, rx_evt, wk;
	logic [8:0] got;
	int err_count, tests_run, cyc, c;
	wire logic tx_pin = tx_oe_n ? 1'b1 : tx_out; // pulled up when free
	wire logic rx_pin = rx_oe_n ? peer_tx : rx_out;
	stcb_core uut (.i_ref_clk(clk), .i_resetn(rst_n), .i_clk_en(1'b1),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
		.o_rdata(rdata), .i_tx_clk_in(tx_pin), .o_tx_clk_out(tx_out),
		.o_tx_clk_oe_n(tx_oe_n), .i_rx_dat_in(rx_pin),
		.o_rx_dat_out(rx_out), .o_rx_dat_oe_n(rx_oe_n),
		.o_tx_buf_full(buf_full), .o_rx_ready(rx_rdy),
		.o_rx_event(rx_evt), .o_wake_event(wk));
	stcb_peer peer (.i_clk(clk), .i_line(tx_pin), .o_line(peer_tx));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// hang guard: whole run needs well under this many cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop;
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [8:0] e,
		input logic [8:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// let k edges pass, then step off the edge so outputs have settled
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e,
		input logic [7:0] m, input string n);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(n, {1'b0, e}, {1'b0, rdata & m});
	endtask
	task automatic wait_rdy;
		int i;
		for (i = 0; i < 100 && rx_rdy !== 1'b1; i++)
			tick(1);
		chk("rx_ready", 9'h001, {8'h00, rx_rdy});
	endtask
	task automatic t_reset;
		rd_chk(ADDR_TX_CTRL, 8'h02, 8'hFF, "tx_ctrl");
		rd_chk(ADDR_RX_CTRL, 8'h00, 8'hFF, "rx_ctrl");
		rd_chk(ADDR_BAUD_CTRL, 8'h40, 8'hFF, "baud_ctrl");
		rd_chk(3'h7, 8'h00, 8'hFF, "unmapped");
		reg_wr(ADDR_BAUD_CTRL, 8'hFF);
		rd_chk(ADDR_BAUD_CTRL, 8'hDB, 8'hFF, "baud_bits");
		reg_wr(ADDR_BAUD_CTRL, 8'h00);
	endtask
	// one frame out: divider n, high speed hs, b clocks per bit
	task automatic t_tx(input logic hs, input logic [7:0] n, input int b,
		input logic [8:0] d, input int nb);
		reg_wr(ADDR_DIV_LO, n);
		reg_wr(ADDR_TX_CTRL, {1'b0, nb == 9, 3'h4, hs, 1'b0, d[8]});
		reg_wr(ADDR_RX_CTRL, 8'h80);
		fork
			peer.recv(got, nb, b);
			begin
				reg_wr(ADDR_TX_DATA, d[7:0]);
				tick(4); // load waits for the next baud tick
				rd_chk(ADDR_TX_CTRL, 8'h00, 8'h02, "tsr_busy");
			end
		join
		chk("tx_frame", d, got);
		tick(2 * b);
		rd_chk(ADDR_TX_CTRL, 8'h02, 8'h02, "tsr_empty");
	endtask
	task automatic t_rx;
		reg_wr(ADDR_DIV_LO, 8'h01); // 32 clocks per bit at high speed
		reg_wr(ADDR_TX_CTRL, 8'h04);
		reg_wr(ADDR_RX_CTRL, 8'hD8);
		peer.send(9'h0A5, 9, 32, 1'b1);
		tick(8);
		chk("addr_drop", 9'h000, {8'h00, rx_rdy});
		peer.send(9'h15A, 9, 32, 1'b1);
		wait_rdy();
		rd_chk(ADDR_RX_CTRL, 8'hD9, 8'hFF, "rx_ninth");
		rd_chk(ADDR_RX_DATA, 8'h5A, 8'hFF, "rx_data");
		reg_wr(ADDR_RX_CTRL, 8'h90);
		peer.send(9'h03C, 8, 32, 1'b0);
		wait_rdy();
		rd_chk(ADDR_RX_CTRL, 8'h94, 8'hFF, "framing_error_flag_set");
		rd_chk(ADDR_RX_DATA, 8'h3C, 8'hFF, "rx_data");
		peer.send(9'h0C3, 8, 32, 1'b1);
		wait_rdy();
		rd_chk(ADDR_RX_CTRL, 8'h90, 8'hFF, "framing_error_flag_upd");
		rd_chk(ADDR_RX_DATA, 8'hC3, 8'hFF, "rx_data");
	endtask
	task automatic t_misc;
		int i;
		reg_wr(ADDR_DIV_LO, 8'h07);
		reg_wr(ADDR_BAUD_CTRL, 8'h01);
		peer.send(9'h055, 8, 40, 1'b1);
		tick(8);
		rd_chk(ADDR_DIV_LO, 8'h01, 8'hFF, "abd_div");
		rd_chk(ADDR_BAUD_CTRL, 8'h00, 8'h01, "abd_en");
		reg_wr(ADDR_TX_CTRL, 8'h2C);
		fork
			peer.lowtime(c);
			reg_wr(ADDR_TX_DATA, 8'h00);
		join
		chk("brk_len", 9'h180, c[8:0]);
		tick(40);
		rd_chk(ADDR_TX_CTRL, 8'h00, 8'h08, "brk_clr");
		reg_wr(ADDR_RX_CTRL, 8'h80);
		reg_wr(ADDR_BAUD_CTRL, 8'h02);
		fork
			peer.drive(1'b0, 12);
			for (i = 0; i < 10 && wk !== 1'b1; i++)
				tick(1);
		join_any
		chk("wake", 9'h001, {8'h00, wk});
		wait fork;
		peer.drive(1'b1, 4);
		rd_chk(ADDR_BAUD_CTRL, 8'h00, 8'h02, "wake_clr");
		reg_wr(ADDR_BAUD_CTRL, 8'h10);
		reg_wr(ADDR_TX_CTRL, 8'h90);
		tick(4);
		chk("clk_drive", 9'h000, {8'h00, tx_oe_n});
		chk("clk_idle", 9'h001, {8'h00, tx_pin});
		chk("dat_free", 9'h003, {7'h00, rx_oe_n, rx_out});
		reg_wr(ADDR_BAUD_CTRL, 8'h00);
		tick(4);
		chk("clk_idle", 9'h000, {8'h00, tx_pin});
		reg_wr(ADDR_TX_CTRL, 8'h10);
		tick(4);
		chk("clk_slave", 9'h001, {8'h00, tx_oe_n});
	endtask
	initial
	begin
		rst_n = 1'b0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_tx(1'b1, 8'h01, 32, 9'h0A5, 8);
		t_tx(1'b0, 8'h00, 64, 9'h1C3, 9);
		t_rx();
		t_misc();
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
